// [hw/ums_pkg.sv]
// constants, carriers and state layout of the modem status block
package ums_pkg;

    // -------------------------------------------------------------
    // register byte addresses
    // -------------------------------------------------------------
    localparam int ADR_W = 8;
    localparam logic [7:0] ADR_MSR = 8'h00;
    localparam logic [7:0] ADR_SPR = 8'h04;
    localparam logic [7:0] ADR_EFR = 8'h08;
    localparam logic [7:0] ADR_MCR = 8'h0C;
    localparam logic [7:0] ADR_LVL = 8'h10;

    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_OP1 = 2;
    localparam int MCR_OP2 = 3;
    localparam int MCR_LOOP = 4;
    localparam logic [7:0] MCR_STD_MASK = 8'h1F;
    localparam int EFR_ENH = 4;
    localparam int EFR_ARTS = 6;
    localparam int EFR_ACTS = 7;
    localparam int IN_CTS = 0;
    localparam int IN_DSR = 1;
    localparam int IN_RI = 2;
    localparam int IN_CD = 3;

    // -------------------------------------------------------------
    // reset values and warm-up end count
    // -------------------------------------------------------------
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam logic [7:0] EFR_RST = 8'h00;
    localparam logic [7:0] SPR_RST = 8'h00;
    localparam logic [3:0] DELTA_RST = 4'h0;
    localparam logic [3:0] PIN_RST = 4'hF;
    localparam logic [7:0] LVL_TRIG_RST = 8'h08;
    localparam logic [7:0] LVL_NEXT_RST = 8'h10;
    localparam logic [7:0] LVL_LOW_RST = 8'h04;
    localparam logic [1:0] WARM_DONE = 2'h3;

    // -------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------
    typedef struct packed {
        logic cd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } ums_modem_in_s;

    typedef struct packed {
        logic op2_n;
        logic op1_n;
        logic dtr_n;
        logic rts_n;
    } ums_modem_out_s;

    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic [1:0] warm;
        logic [3:0] delta;
        logic [7:0] modem_output_ctl;
        logic [7:0] enhanced_feature_ctl;
        logic [7:0] scratch_byte;
        logic [7:0] lvl_trig;
        logic [7:0] lvl_next;
        logic [7:0] lvl_low;
        logic rts_blk;
        logic ack;
        logic [31:0] dat;
        ums_modem_out_s mout;
        logic irq;
        logic trig;
        logic hold;
        logic loop;
        logic [3:0] flow;
        logic tx_dual;
        logic rx_dual;
    } ums_state_s;

endpackage : ums_pkg

// [hw/ums_modem_status.sv]
// modem status, flow control and scratch registers of one channel
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps

module ums_modem_status #(
    parameter int FW = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ums_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire ums_pkg::ums_modem_in_s modem_i,
    output ums_pkg::ums_modem_out_s modem_o,
    input wire logic [FW-1:0] rx_fill_i,
    output logic modem_irq_o,
    output logic rx_trig_o,
    output logic tx_hold_o,
    output logic loopback_o,
    output logic [3:0] sw_flow_o,
    output logic tx_pair_o,
    output logic rx_pair_o
);

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    localparam ums_pkg::ums_state_s ST_RST = '{
        sync1: ums_pkg::PIN_RST,
        sync2: ums_pkg::PIN_RST,
        prev: ums_pkg::PIN_RST,
        warm: 2'h0,
        delta: ums_pkg::DELTA_RST,
        modem_output_ctl: ums_pkg::MCR_RST,
        enhanced_feature_ctl: ums_pkg::EFR_RST,
        scratch_byte: ums_pkg::SPR_RST,
        lvl_trig: ums_pkg::LVL_TRIG_RST,
        lvl_next: ums_pkg::LVL_NEXT_RST,
        lvl_low: ums_pkg::LVL_LOW_RST,
        rts_blk: 1'b0,
        ack: 1'b0,
        dat: 32'h0000_0000,
        mout: 4'hF,
        irq: 1'b0,
        trig: 1'b0,
        hold: 1'b0,
        loop: 1'b0,
        flow: 4'h0,
        tx_dual: 1'b0,
        rx_dual: 1'b0
    };

    ums_pkg::ums_state_s st_q;
    ums_pkg::ums_state_s st_d;

    logic req;
    logic rd_msr;
    logic [3:0] pin;
    logic [3:0] ev;
    logic [7:0] modem_line_state;
    logic [7:0] mcr_eff;
    logic [7:0] fill;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic hit(
        input logic [ums_pkg::ADR_W-1:0] a,
        input logic [7:0] r
    );
        hit = (a == r);
    endfunction : hit

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        req = wb_cyc_i & wb_stb_i & ~st_q.ack;
        rd_msr = req & ~wb_we_i & hit(wb_adr_i, ums_pkg::ADR_MSR);
        fill = 8'(rx_fill_i);

        // enhanced bits vanish but stay stored
        mcr_eff = st_q.enhanced_feature_ctl[ums_pkg::EFR_ENH] ? st_q.modem_output_ctl :
            (st_q.modem_output_ctl & ums_pkg::MCR_STD_MASK);

        // two stage synchroniser, only sync2 is looked at
        st_d.sync1 = modem_i;
        st_d.sync2 = st_q.sync1;

        // pin level seen by the status logic
        if (st_q.modem_output_ctl[ums_pkg::MCR_LOOP]) begin
            pin = ~{st_q.modem_output_ctl[ums_pkg::MCR_OP2],
                    st_q.modem_output_ctl[ums_pkg::MCR_OP1],
                    st_q.modem_output_ctl[ums_pkg::MCR_DTR],
                    st_q.modem_output_ctl[ums_pkg::MCR_RTS]};
        end else begin
            pin = st_q.sync2;
        end
        st_d.prev = pin;

        // warm-up keeps reset release from faking a change
        if (st_q.warm != ums_pkg::WARM_DONE) begin
            st_d.warm = st_q.warm + 2'h1;
        end

        ev = 4'h0;
        if (st_q.warm == ums_pkg::WARM_DONE) begin
            ev[ums_pkg::IN_CD] = pin[3] ^ st_q.prev[3];
            ev[ums_pkg::IN_RI] = pin[2] & ~st_q.prev[2];
            ev[ums_pkg::IN_DSR] = pin[1] ^ st_q.prev[1];
            ev[ums_pkg::IN_CTS] = pin[0] ^ st_q.prev[0];
        end

        // upper half is live, lower half the sticky changes
        modem_line_state = {~st_q.prev, st_q.delta};

        // a change in the read cycle survives the clear
        st_d.delta = (rd_msr ? ums_pkg::DELTA_RST : st_q.delta)
            | ev;

        // ---------------------------------------------------------
        // bus slave
        // ---------------------------------------------------------
        st_d.ack = req;
        st_d.dat = 32'h0000_0000;
        if (req & ~wb_we_i) begin
            case (wb_adr_i)
                ums_pkg::ADR_MSR: st_d.dat = {24'h00_0000, modem_line_state};
                ums_pkg::ADR_SPR: st_d.dat = {24'h00_0000, st_q.scratch_byte};
                ums_pkg::ADR_EFR: st_d.dat = {24'h00_0000, st_q.enhanced_feature_ctl};
                ums_pkg::ADR_MCR: st_d.dat = {24'h00_0000, mcr_eff};
                ums_pkg::ADR_LVL: begin
                    st_d.dat = {8'h00, st_q.lvl_low,
                        st_q.lvl_next, st_q.lvl_trig};
                end
                default: st_d.dat = 32'h0000_0000;
            endcase
        end

        if (req & wb_we_i) begin
            case (wb_adr_i)
                ums_pkg::ADR_SPR: begin
                    if (wb_sel_i[0]) begin
                        st_d.scratch_byte = wb_dat_i[7:0];
                    end
                end
                ums_pkg::ADR_EFR: begin
                    if (wb_sel_i[0]) begin
                        st_d.enhanced_feature_ctl = wb_dat_i[7:0];
                    end
                end
                ums_pkg::ADR_MCR: begin
                    if (wb_sel_i[0]) begin
                        st_d.modem_output_ctl = wb_dat_i[7:0];
                    end
                end
                ums_pkg::ADR_LVL: begin
                    if (wb_sel_i[0]) begin
                        st_d.lvl_trig = wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        st_d.lvl_next = wb_dat_i[15:8];
                    end
                    if (wb_sel_i[2]) begin
                        st_d.lvl_low = wb_dat_i[23:16];
                    end
                end
                default: begin
                    st_d.dat = 32'h0000_0000;
                end
            endcase
        end

        // ---------------------------------------------------------
        // flow control and outputs
        // ---------------------------------------------------------
        st_d.irq = |st_d.delta;

        // hysteresis between next and lower level
        if (!st_q.enhanced_feature_ctl[ums_pkg::EFR_ARTS]) begin
            st_d.rts_blk = 1'b0;
        end else if (st_q.rts_blk) begin
            st_d.rts_blk = (fill >= st_q.lvl_low);
        end else begin
            st_d.rts_blk = (fill >= st_q.lvl_next);
        end
        st_d.trig = st_q.enhanced_feature_ctl[ums_pkg::EFR_ARTS] &
            (fill >= st_q.lvl_trig);

        // outputs held inactive while looped back
        st_d.loop = st_q.modem_output_ctl[ums_pkg::MCR_LOOP];
        st_d.mout.rts_n = st_d.loop | st_d.rts_blk |
            ~mcr_eff[ums_pkg::MCR_RTS];
        st_d.mout.dtr_n = st_d.loop | ~mcr_eff[ums_pkg::MCR_DTR];
        st_d.mout.op1_n = st_d.loop | ~mcr_eff[ums_pkg::MCR_OP1];
        st_d.mout.op2_n = st_d.loop | ~mcr_eff[ums_pkg::MCR_OP2];

        st_d.hold = st_q.enhanced_feature_ctl[ums_pkg::EFR_ACTS] & pin[0];

        // matcher and sender outside read these
        st_d.flow = st_q.enhanced_feature_ctl[3:0];
        st_d.tx_dual = st_q.enhanced_feature_ctl[3] & st_q.enhanced_feature_ctl[2];
        st_d.rx_dual = st_q.enhanced_feature_ctl[1] & st_q.enhanced_feature_ctl[0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign wb_dat_o = st_q.dat;
    assign wb_ack_o = st_q.ack;
    assign modem_o = st_q.mout;
    assign modem_irq_o = st_q.irq;
    assign rx_trig_o = st_q.trig;
    assign tx_hold_o = st_q.hold;
    assign loopback_o = st_q.loop;
    assign sw_flow_o = st_q.flow;
    assign tx_pair_o = st_q.tx_dual;
    assign rx_pair_o = st_q.rx_dual;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_msr_read;
        req && !wb_we_i && wb_adr_i == ums_pkg::ADR_MSR;
    endsequence

    sequence s_spr_write;
        req && wb_we_i && wb_sel_i[0] &&
            wb_adr_i == ums_pkg::ADR_SPR;
    endsequence

    sequence s_quiet;
        ev == 4'h0;
    endsequence

    AST_CHANGE_SETS: assert property (
        ev != 4'h0 |=> (st_q.delta & $past(ev)) == $past(ev))
        else $error("input change did not set its bit");

    AST_BOTH_EDGES: assert property (
        (st_q.warm == ums_pkg::WARM_DONE && !st_q.modem_output_ctl[4] &&
            st_q.sync2[3] != st_q.prev[3]) |=> st_q.delta[3])
        else $error("cd edge missed");

    AST_READ_CLEARS: assert property (
        (s_msr_read and s_quiet) |=> st_q.delta == 4'h0 &&
            wb_ack_o && wb_dat_o[3:0] == $past(st_q.delta))
        else $error("status read did not clear changes");

    AST_LOOP_UPPER: assert property (
        $past(st_q.modem_output_ctl[4]) |-> ~st_q.prev ==
            {$past(st_q.modem_output_ctl[3]), $past(st_q.modem_output_ctl[2]),
             $past(st_q.modem_output_ctl[0]), $past(st_q.modem_output_ctl[1])})
        else $error("loopback status bits wrong");

    AST_NORMAL_UPPER: assert property (
        (!$past(st_q.modem_output_ctl[4]) && !$past(st_q.modem_output_ctl[4], 2)) |->
            st_q.prev == $past(st_q.sync1, 2))
        else $error("live status not two stages behind");

    AST_RI_FALL_IGNORED: assert property (
        (st_q.prev[2] && !pin[2] && !rd_msr) |=>
            st_q.delta[2] == $past(st_q.delta[2]))
        else $error("ri falling edge set change bit");

    AST_IRQ_TIES: assert property (
        modem_irq_o == (st_q.delta != 4'h0))
        else $error("modem interrupt not tied to changes");

    AST_NO_CHANGE_ZERO: assert property (
        (st_q.delta == 4'h0 ##0 s_quiet) |=> st_q.delta == 4'h0)
        else $error("change bit set with no change");

    AST_SCRATCH: assert property (
        s_spr_write |=> st_q.scratch_byte == $past(wb_dat_i[7:0]))
        else $error("scratch write lost");

    AST_CTS_HOLD: assert property (
        (st_q.enhanced_feature_ctl[7] && pin[0]) |=> tx_hold_o)
        else $error("transmitter not held on cts high");

    AST_RTS_RAISE: assert property (
        (st_q.enhanced_feature_ctl[6] && fill >= st_q.lvl_next) |=>
            modem_o.rts_n)
        else $error("rts not raised at next level");

    AST_RTS_DROP: assert property (
        (st_q.rts_blk && st_q.enhanced_feature_ctl[6] && fill < st_q.lvl_low)
            |=> !st_q.rts_blk)
        else $error("rts block not released");

    AST_RTS_FOLLOW: assert property (
        (!st_q.enhanced_feature_ctl[6] && !st_q.modem_output_ctl[4]) |=>
            modem_o.rts_n == !$past(mcr_eff[1]))
        else $error("rts does not follow control bit");

    AST_ENH_MASK: assert property (
        (!st_q.enhanced_feature_ctl[4] && req && !wb_we_i &&
            wb_adr_i == ums_pkg::ADR_MCR) |=>
            wb_dat_o[7:5] == 3'h0)
        else $error("enhanced control bits visible");

    AST_PAIR: assert property (
        tx_pair_o == ($past(st_q.enhanced_feature_ctl[3]) && $past(st_q.enhanced_feature_ctl[2])))
        else $error("transmit pair flag wrong");

    AST_RESET_CLEAR: assert property (
        $past(rst_i) |-> st_q.delta == 4'h0 && !modem_irq_o)
        else $error("change bits not cleared by reset");

    AST_ACK_PULSE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    AST_RI_RISE: assert property (
        (st_q.warm == ums_pkg::WARM_DONE && !st_q.prev[2] && pin[2])
            |=> st_q.delta[2])
        else $error("ri rising edge missed");

    AST_HOLD_RELEASE: assert property (
        (!st_q.enhanced_feature_ctl[7] || !pin[0]) |=> !tx_hold_o)
        else $error("transmitter held without cts high");

    AST_TRIG: assert property (
        (st_q.enhanced_feature_ctl[6] && fill >= st_q.lvl_trig) |=>
            rx_trig_o)
        else $error("trigger level not flagged");

    AST_LOOP_OUTS: assert property (
        st_q.modem_output_ctl[4] |=> modem_o == 4'hF && loopback_o)
        else $error("outputs not parked in loopback");

    AST_FLOW: assert property (
        sw_flow_o == $past(st_q.enhanced_feature_ctl[3:0]))
        else $error("software flow select wrong");

    AST_ENH_SHOW: assert property (
        (st_q.enhanced_feature_ctl[4] && req && !wb_we_i &&
            wb_adr_i == ums_pkg::ADR_MCR) |=>
            wb_dat_o[7:0] == $past(st_q.modem_output_ctl))
        else $error("stored control bits not restored");

endmodule : ums_modem_status

// [test/ums_modem_peer.sv]
// modem-side partner driving the four active-low status pins
`timescale 1ns/1ps

module ums_modem_peer (
    input wire logic clk_i,
    input wire logic [3:0] want_i,
    input wire logic slow_i,
    output ums_pkg::ums_modem_in_s pins_o
);
    // ------------------------------------------------------------
    // pins move on the falling edge, away from the sampling edge
    // ------------------------------------------------------------
    logic [3:0] stage_q = 4'hF;
    logic [3:0] pin_q = 4'hF;

    // a slow modem settles its lines one cycle late
    always @(negedge clk_i) begin
        stage_q <= want_i;
        pin_q <= slow_i ? stage_q : want_i;
    end

    assign pins_o = pin_q;
endmodule : ums_modem_peer

// [test/testbench.sv]
// self-checking bench for the modem status block
`timescale 1ns/1ps

module testbench;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [ums_pkg::ADR_W-1:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    ums_pkg::ums_modem_in_s modem_i;
    ums_pkg::ums_modem_out_s modem_o;
    logic [5:0] rx_fill_i = 6'h00;
    logic modem_irq_o, rx_trig_o, tx_hold_o, loopback_o;
    logic [3:0] sw_flow_o;
    logic tx_pair_o, rx_pair_o;
    logic [3:0] want = 4'hF;
    logic slow = 1'b0;
    logic [3:0] dlt = 4'h0;
    logic [31:0] lfsr = 32'h2A7E;
    logic [31:0] rd;
    logic [5:0] fills [6] = '{6'h07, 6'h08, 6'h10, 6'h09, 6'h04, 6'h03};
    logic [5:0] trig_v = 6'b001110;
    logic [5:0] rts_v = 6'b011100;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;

    initial forever #2 clk_i = ~clk_i;

    ums_modem_status #(.FW(6)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .modem_i(modem_i),
        .modem_o(modem_o), .rx_fill_i(rx_fill_i),
        .modem_irq_o(modem_irq_o), .rx_trig_o(rx_trig_o),
        .tx_hold_o(tx_hold_o), .loopback_o(loopback_o),
        .sw_flow_o(sw_flow_o), .tx_pair_o(tx_pair_o),
        .rx_pair_o(rx_pair_o));

    ums_modem_peer peer (.clk_i(clk_i), .want_i(want), .slow_i(slow),
        .pins_o(modem_i));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        if (miscompares == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // classic cycle: held until ack is seen at a rising edge
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp,
                         input string what);
        wb(1'b0, adr, 32'h0);
        check(what, exp, rd);
    endtask : rdchk

    // model: cd/dsr/cts flag both edges, ri flags pin rise only
    task automatic set_pins(input logic [3:0] v);
        dlt = dlt | ((want ^ v) & 4'b1011) | (~want & v & 4'b0100);
        want = v;
        repeat (8) @(posedge clk_i);
        check("modem_irq", {31'h0, dlt != 4'h0}, {31'h0, modem_irq_o});
    endtask : set_pins

    task automatic read_msr();
        wb(1'b0, ums_pkg::ADR_MSR, 32'h0);
        check("modem_line_state", {24'h0, ~want, dlt}, rd);
        dlt = 4'h0;
    endtask : read_msr

    // ------------------------------------------------------------
    // hang guard
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        check("modem_o", 32'hF, {28'h0, modem_o});
        rdchk(ums_pkg::ADR_MSR, 32'h0, "modem_line_state");
        rdchk(ums_pkg::ADR_MCR, 32'h0, "modem_output_ctl");
        rdchk(ums_pkg::ADR_EFR, 32'h0, "enhanced_feature_ctl");
        rdchk(ums_pkg::ADR_LVL, 32'h00041008, "levels");
        rdchk(8'h14, 32'h0, "unmapped");
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            wb(1'b1, ums_pkg::ADR_SPR, {24'h0, lfsr[7:0]});
            rdchk(ums_pkg::ADR_SPR, {24'h0, lfsr[7:0]}, "scratch_byte");
            check("modem_irq", 32'h0, {31'h0, modem_irq_o});
        end
        // each pin low then high, then random piles of changes
        for (int b = 0; b < 4; b++) begin
            set_pins(4'hF ^ (4'h1 << b));
            read_msr();
            read_msr();
            set_pins(4'hF);
            read_msr();
        end
        for (int i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            slow = lfsr[8];
            set_pins(lfsr[3:0]);
            if (lfsr[9]) begin
                read_msr();
            end
        end
        read_msr();
        set_pins(4'hF);
        read_msr();
        for (int m = 0; m < 16; m++) begin
            wb(1'b1, ums_pkg::ADR_MCR, 32'h10 | m);
            repeat (6) @(posedge clk_i);
            wb(1'b0, ums_pkg::ADR_MSR, 32'h0);
            check("loop_state", {28'h0, m[3], m[2], m[0], m[1]},
                  {28'h0, rd[7:4]});
            check("loop_pins", 32'hF, {28'h0, modem_o});
            check("loopback", 32'h1, {31'h0, loopback_o});
        end
        wb(1'b1, ums_pkg::ADR_MCR, 32'h0B);
        repeat (6) @(posedge clk_i);
        check("modem_o", 32'h4, {28'h0, modem_o});
        check("loopback", 32'h0, {31'h0, loopback_o});
        wb(1'b0, ums_pkg::ADR_MSR, 32'h0);
        dlt = 4'h0;
        read_msr();
        for (int e = 0; e < 16; e++) begin
            wb(1'b1, ums_pkg::ADR_EFR, 32'h10 | e);
            rdchk(ums_pkg::ADR_EFR, 32'h10 | e, "enhanced_feature_ctl");
            check("sw_flow", e, {28'h0, sw_flow_o});
            check("pairs", {30'h0, e[3] & e[2], e[1] & e[0]},
                  {30'h0, tx_pair_o, rx_pair_o});
        end
        wb(1'b1, ums_pkg::ADR_MCR, 32'hE2);
        rdchk(ums_pkg::ADR_MCR, 32'hE2, "modem_output_ctl");
        wb(1'b1, ums_pkg::ADR_EFR, 32'h00);
        rdchk(ums_pkg::ADR_MCR, 32'h02, "modem_output_ctl");
        wb(1'b1, ums_pkg::ADR_EFR, 32'h10);
        rdchk(ums_pkg::ADR_MCR, 32'hE2, "modem_output_ctl");
        wb(1'b1, ums_pkg::ADR_EFR, 32'h80);
        set_pins(4'hF);
        check("tx_hold", 32'h1, {31'h0, tx_hold_o});
        set_pins(4'hE);
        check("tx_hold", 32'h0, {31'h0, tx_hold_o});
        set_pins(4'hF);
        check("tx_hold", 32'h1, {31'h0, tx_hold_o});
        wb(1'b1, ums_pkg::ADR_EFR, 32'h40);
        repeat (3) @(posedge clk_i);
        check("tx_hold", 32'h0, {31'h0, tx_hold_o});
        read_msr();
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_i);
            rx_fill_i <= fills[i];
            repeat (3) @(posedge clk_i);
            check("rx_trig", {31'h0, trig_v[i]}, {31'h0, rx_trig_o});
            check("rts_n", {31'h0, rts_v[i]}, {31'h0, modem_o.rts_n});
        end
        @(posedge clk_i);
        rx_fill_i <= 6'h10;
        repeat (3) @(posedge clk_i);
        check("rts_n", 32'h1, {31'h0, modem_o.rts_n});
        wb(1'b1, ums_pkg::ADR_EFR, 32'h00);
        repeat (3) @(posedge clk_i);
        check("rts_n", 32'h0, {31'h0, modem_o.rts_n});
        // mid-run reset: changes pending, pins left away from idle
        set_pins(4'h6);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        dlt = 4'h0;
        repeat (4) @(posedge clk_i);
        check("modem_o", 32'hF, {28'h0, modem_o});
        read_msr();
        end_sim();
    end
endmodule : testbench
